// ===== verilog/dmadsc_defs.vh
// constants for the descriptor mode decode block
`ifndef DMADSC_DEFS_VH
`define DMADSC_DEFS_VH
`define DMADSC_PTR_W      24
`define DMADSC_SRC_HI     7
`define DMADSC_SRC_LO     6
`define DMADSC_DST_HI     5
`define DMADSC_DST_LO     4
`define DMADSC_MODE_HI    3
`define DMADSC_MODE_LO    2
`define DMADSC_SIDE       1
`define DMADSC_SIZE       0
`define DMADSC_CHAIN      7
`define DMADSC_IRQ_EVERY  6
`define DMADSC_UPD_ADD    2'h2
`define DMADSC_UPD_SUB    2'h3
`define DMADSC_MODE_NORM  2'h0
`define DMADSC_MODE_RPT   2'h1
`define DMADSC_MODE_BLK   2'h2
`define DMADSC_MODE_BAD   2'h3
`define DMADSC_STEP_BYTE  24'h000001
`define DMADSC_STEP_WORD  24'h000002
`define DMADSC_ZERO8      8'h00
`define DMADSC_ZERO24     24'h000000
`endif

// ===== verilog/dmadsc_ptr_update.v
// pointer update unit: hold, add or subtract by unit size
`timescale 1ns/1ns
`include "dmadsc_defs.vh"
module dmadsc_ptr_update #(
    parameter W = `DMADSC_PTR_W
) (
    input  wire [W-1:0] i_ptr,
    input  wire [1:0]   i_update,
    input  wire         i_unit_size,
    output wire [W-1:0] o_ptr
);
    wire [W-1:0] step;
    // step of one byte or one word
    assign step  = i_unit_size ? `DMADSC_STEP_WORD : `DMADSC_STEP_BYTE;
    // 0x holds, 10 adds, 11 subtracts; wraps at W bits
    assign o_ptr = (i_update == `DMADSC_UPD_ADD) ? i_ptr + step :
                   (i_update == `DMADSC_UPD_SUB) ? i_ptr - step :
                   i_ptr;
endmodule // dmadsc_ptr_update

// ===== verilog/dmadsc_top.v
// descriptor working registers and mode decode of the transfer controller
// Notes on behaviour
// - source pointer: 0x hold, 10 add, 11 subtract
// - dest pointer: 0x hold, 10 add, 11 subtract
// - mode 00 normal, 01 repeat, 10 block
// - side bit: 0 destination area, 1 source
// - unit size bit: 0 byte, 1 word
// - chain bit continues with next descriptor
// - chained move skips end check and clears
// - irq select 1: interrupt after every unchained move
// - irq select 0: interrupt at count end of an unchained move
// - low six mode_reg_b bits ignored
// - 24-bit source pointer, even for words
// - 24-bit dest pointer, even for words
// - load descriptor on activation, write back after
// - working registers hidden from the cpu
`timescale 1ns/1ns
`include "dmadsc_defs.vh"
module dmadsc_top #(
    parameter W = `DMADSC_PTR_W
) (
    input  wire         i_sys_clk,
    input  wire         i_resetn,
    input  wire         i_clk_en,
    input  wire         i_load,
    input  wire [7:0]   i_mode_reg_a,
    input  wire [7:0]   i_mode_reg_b,
    input  wire [W-1:0] i_source_pointer,
    input  wire [W-1:0] i_dest_pointer,
    input  wire         i_move_done,
    input  wire         i_count_end,
    output reg          o_writeback,
    output reg  [7:0]   o_mode_reg_a,
    output reg  [7:0]   o_mode_reg_b,
    output reg  [W-1:0] o_source_pointer,
    output reg  [W-1:0] o_dest_pointer,
    output reg  [1:0]   o_xfer_mode,
    output reg          o_repeat_src_side,
    output reg          o_repeat_dst_side,
    output reg          o_unit_size,
    output reg          o_chain_next,
    output reg          o_end_check,
    output reg          o_clear_source,
    output reg          o_irq_req,
    output reg          o_mode_illegal
);
    ////////////////////////////////////////////////////////////////////////////
    // working registers, loaded only from the descriptor ram copy
    reg  [7:0]   mode_reg_a;
    reg  [7:0]   mode_reg_b;
    reg  [W-1:0] source_pointer;
    reg  [W-1:0] dest_pointer;
    wire [W-1:0] next_source_pointer;
    wire [W-1:0] next_dest_pointer;

    ////////////////////////////////////////////////////////////////////////////
    // timing, counted in enabled clock edges:
    //   load taken at one edge, working registers set by that edge
    //   decoded view lags the working registers by one edge
    //   move taken at one edge, pulses and write-back words after it
    //   pulses last one enabled cycle, words stand until the next move
    //   a load and a move together: the load wins, the move is lost
    //   mode code 11 is flagged only, neither repeat nor block
    //   odd pointers with word size pass unchecked, software keeps them even

    ////////////////////////////////////////////////////////////////////////////
    // decoded fields and accepted strobes
    wire [1:0] src_update;
    wire [1:0] dst_update;
    wire [1:0] xfer_mode;
    wire       area_side_select;
    wire       unit_size;
    wire       chain_enable;
    wire       irq_every_move;
    wire       repeat_or_block;
    wire       mode_illegal;
    wire       take_load;
    wire       take_move;

    // mode fields of the working registers
    assign src_update       = mode_reg_a[`DMADSC_SRC_HI:`DMADSC_SRC_LO];
    assign dst_update       = mode_reg_a[`DMADSC_DST_HI:`DMADSC_DST_LO];
    assign xfer_mode        = mode_reg_a[`DMADSC_MODE_HI:`DMADSC_MODE_LO];
    assign area_side_select = mode_reg_a[`DMADSC_SIDE];
    assign unit_size        = mode_reg_a[`DMADSC_SIZE];
    assign chain_enable     = mode_reg_b[`DMADSC_CHAIN];     // low bits unread
    assign irq_every_move   = mode_reg_b[`DMADSC_IRQ_EVERY];
    assign repeat_or_block  = (xfer_mode == `DMADSC_MODE_RPT) ||
                              (xfer_mode == `DMADSC_MODE_BLK);
    assign mode_illegal     = (xfer_mode == `DMADSC_MODE_BAD);

    // a load in the same cycle swallows the move
    assign take_load        = i_load;
    assign take_move        = i_move_done & ~i_load;

    ////////////////////////////////////////////////////////////////////////////
    // completion pulses for one accepted move
    reg          next_writeback;
    reg          next_chain_next;
    reg          next_end_check;
    reg          next_clear_source;
    reg          next_irq_req;

    // a chained move skips the end check and leaves the source alone
    always @* begin
        next_writeback    = 1'h0;
        next_chain_next   = 1'h0;
        next_end_check    = 1'h0;
        next_clear_source = 1'h0;
        next_irq_req      = 1'h0;
        if (take_move) begin
            next_writeback  = 1'h1;
            next_chain_next = chain_enable;
            if (!chain_enable) begin
                next_end_check    = 1'h1;
                next_clear_source = i_count_end;
                next_irq_req      = irq_every_move | i_count_end;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer update units, entry 0 destination and entry 1 source
    localparam PTR_N = 2;
    localparam UPD_W = 2;
    wire [PTR_N*W-1:0]     ptr_pair;
    wire [PTR_N*UPD_W-1:0] upd_pair;
    wire [PTR_N*W-1:0]     next_pair;
    genvar                 gi;

    assign ptr_pair = {source_pointer, dest_pointer};
    assign upd_pair = {src_update, dst_update};

    // both units share the unit size step
    generate
        for (gi = 0; gi < PTR_N; gi = gi + 1) begin : g_ptr
            dmadsc_ptr_update #(
                .W (W)
            ) u_ptr (
                .i_ptr       (ptr_pair[gi*W +: W]),
                .i_update    (upd_pair[gi*UPD_W +: UPD_W]),
                .i_unit_size (unit_size),
                .o_ptr       (next_pair[gi*W +: W])
            );
        end
    endgenerate

    assign next_dest_pointer   = next_pair[W-1:0];
    assign next_source_pointer = next_pair[PTR_N*W-1:W];

    ////////////////////////////////////////////////////////////////////////////
    // working registers: loaded on activation, pointers updated on each move
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_reg_a     <= `DMADSC_ZERO8;
            mode_reg_b     <= `DMADSC_ZERO8;
            source_pointer <= `DMADSC_ZERO24;
            dest_pointer   <= `DMADSC_ZERO24;
        end else if (i_clk_en) begin
            if (take_load) begin
                // activation: take the ram copy, no cpu path exists
                mode_reg_a     <= i_mode_reg_a;
                mode_reg_b     <= i_mode_reg_b;
                source_pointer <= i_source_pointer;
                dest_pointer   <= i_dest_pointer;
            end else if (take_move) begin
                // each pointer holds or steps by the unit size per its update field
                source_pointer <= next_source_pointer;
                dest_pointer   <= next_dest_pointer;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write-back words, held until the next accepted move
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mode_reg_a     <= `DMADSC_ZERO8;
            o_mode_reg_b     <= `DMADSC_ZERO8;
            o_source_pointer <= `DMADSC_ZERO24;
            o_dest_pointer   <= `DMADSC_ZERO24;
        end else if (i_clk_en && take_move) begin
            // the updated set goes back to the ram copy
            o_mode_reg_a     <= mode_reg_a;
            o_mode_reg_b     <= mode_reg_b;
            o_source_pointer <= next_source_pointer;
            o_dest_pointer   <= next_dest_pointer;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion pulses; a low clock enable stretches them
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_writeback    <= 1'h0;
            o_chain_next   <= 1'h0;
            o_end_check    <= 1'h0;
            o_clear_source <= 1'h0;
            o_irq_req      <= 1'h0;
        end else if (i_clk_en) begin
            o_writeback    <= next_writeback;
            o_chain_next   <= next_chain_next;
            o_end_check    <= next_end_check;
            o_clear_source <= next_clear_source;
            o_irq_req      <= next_irq_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded mode view for the transfer sequencer
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_xfer_mode       <= `DMADSC_MODE_NORM;
            o_repeat_src_side <= 1'h0;
            o_repeat_dst_side <= 1'h0;
            o_unit_size       <= 1'h0;
            o_mode_illegal    <= 1'h0;
        end else if (i_clk_en) begin
            o_xfer_mode       <= xfer_mode;
            o_mode_illegal    <= mode_illegal;
            o_repeat_src_side <= repeat_or_block & area_side_select;
            o_repeat_dst_side <= repeat_or_block & ~area_side_select;
            o_unit_size       <= unit_size;
        end
    end
endmodule // dmadsc_top

// ===== verif/dmadsc_props.sv
// port assertions for the descriptor decode block
`timescale 1ns/1ns
module dmadsc_props (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_clk_en,
    input wire i_load,
    input wire i_move_done,
    input wire i_count_end,
    input wire o_writeback,
    input wire o_chain_next,
    input wire o_end_check,
    input wire o_clear_source,
    input wire o_irq_req
);
    wire take = i_clk_en & i_move_done & ~i_load;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    wb_move_a: assert property (i_clk_en |=>
        o_writeback == ($past(i_move_done) && !$past(i_load))) else $error("write-back");
    chain_only_a: assert property (o_writeback |-> o_chain_next != o_end_check)
        else $error("chain");
    idle_quiet_a: assert property (!o_writeback |->
        !(o_chain_next | o_end_check | o_irq_req | o_clear_source)) else $error("idle");
    clr_end_a: assert property (o_clear_source |-> o_end_check) else $error("clear");
    irq_end_a: assert property (o_irq_req |-> o_end_check) else $error("irq");
    clr_count_a: assert property (take |=>
        o_clear_source == (o_end_check && $past(i_count_end))) else $error("clear");
    irq_count_a: assert property (take && i_count_end |=> o_irq_req | o_chain_next)
        else $error("irq");
    en_freeze_a: assert property (!i_clk_en |=>
        $stable({o_writeback, o_chain_next, o_end_check, o_clear_source, o_irq_req}))
        else $error("hold");
endmodule // dmadsc_props
bind dmadsc_top dmadsc_props i_dmadsc_props (.*);

// ===== verif/dmadsc_ram.sv
// descriptor ram model holding one descriptor set
`timescale 1ns/1ns
module dmadsc_ram (
    input  wire        i_sys_clk,
    input  wire        i_we,
    input  wire [63:0] i_wdata,
    output reg  [63:0] o_rdata
);
    always @(posedge i_sys_clk) if (i_we) o_rdata <= i_wdata;
endmodule // dmadsc_ram

// ===== verif/dmadsc_top_tb.sv
// bench for the descriptor decode block
`timescale 1ns/1ns
module dmadsc_top_tb;
    reg         clk = 0, rstn = 0, en = 1, ld = 0, mv = 0, ce = 0, set = 0;
    reg  [63:0] sv = 0;
    wire [63:0] rd, wb;
    wire [10:0] fl;
    integer     fail_count = 0, cmp_count = 0;
    always #25 clk = ~clk;
    dmadsc_ram i_dmadsc_ram (.i_sys_clk(clk), .i_we(set | fl[10]), .i_wdata(set ? sv : wb),
        .o_rdata(rd));
    dmadsc_top i_dmadsc_top (.i_sys_clk(clk), .i_resetn(rstn), .i_clk_en(en), .i_load(ld),
        .i_mode_reg_a(rd[63:56]), .i_mode_reg_b(rd[55:48]), .i_source_pointer(rd[47:24]),
        .i_dest_pointer(rd[23:0]), .i_move_done(mv), .i_count_end(ce), .o_writeback(fl[10]),
        .o_mode_reg_a(wb[63:56]), .o_mode_reg_b(wb[55:48]), .o_source_pointer(wb[47:24]),
        .o_dest_pointer(wb[23:0]), .o_xfer_mode(fl[9:8]), .o_repeat_src_side(fl[7]),
        .o_repeat_dst_side(fl[6]), .o_unit_size(fl[5]), .o_mode_illegal(fl[4]),
        .o_chain_next(fl[3]), .o_end_check(fl[2]), .o_clear_source(fl[1]), .o_irq_req(fl[0]));
    task chk(input [63:0] s, e);
        cmp_count = cmp_count + 1;
        fail_count = fail_count + (s !== e);
        if (s !== e) $display("Error %0t: got %h want %h", $time, s, e);
    endtask
    function [23:0] upd(input [23:0] p, input [1:0] m, input z);
        upd = !m[1] ? p : m[0] ? p - 24'h1 - z : p + 24'h1 + z;
    endfunction
    task run(input [63:0] v, input c);
        @(negedge clk) {set, sv} = {1'h1, v};
        @(negedge clk) {set, ld} = 2'h1;
        @(negedge clk) {ld, mv, ce, en} = {2'h1, c, 1'h0};
        @(negedge clk) en = 1'h1;
        @(negedge clk) mv = 1'h0;
        chk(wb, {v[63:48], upd(v[47:24], v[63:62], v[56]),
            upd(v[23:0], v[61:60], v[56])});
        chk(fl, {1'h1, v[59:58], v[57] & ^v[59:58], ~v[57] & ^v[59:58], v[56], &v[59:58], v[55],
            ~v[55], ~v[55] & c, ~v[55] & (v[54] | c)});
        $display("test done");
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'h1;
        run({8'ha0, 8'h40, 24'hffffff, 24'h000010}, 1'h0);
        run({8'hf5, 8'h00, 24'h000000, 24'h000100}, 1'h0);
        run({8'ha1, 8'h40, 24'h000100, 24'h000200}, 1'h0);
        @(negedge clk) {ld, mv} = 2'h3;
        @(negedge clk) ld = 1'h0;
        chk(fl, 11'h020);
        @(negedge clk) en = 1'h0;
        chk(wb, {16'ha140, 24'h000104, 24'h000204});
        chk(fl, 11'h425);
        @(negedge clk) en = 1'h1;
        chk(fl, 11'h425);
        @(negedge clk) mv = 1'h0;
        chk(wb, {16'ha140, 24'h000106, 24'h000206});
        $display("freeze test done");
        @(negedge clk) rstn = 1'h0;
        @(negedge clk) chk(wb, 64'h0);
        chk(fl, 11'h000);
        rstn = 1'h1;
        $display("reset test done");
        run({8'h3b, 8'h3f, 24'h000200, 24'h000000}, 1'h1);
        run({8'h4e, 8'hc0, 24'h000301, 24'h000005}, 1'h1);
        wrap_up;
    end
    initial begin
        #40000 fail_count = fail_count + 1;
        wrap_up;
    end
endmodule // dmadsc_top_tb
